/* File: src/acrb_top.sv */
// configuration and calibration register bank with serial command port
// ****************************************************************
// Notes on behaviour
// - config zero bits 7,6 read one, zero
// - config zero bits 5,4 give factory code
// - config zero bit 2 enables reference bias
// - config zero bit 0 arms sclk-low timeout
// - config one bit 7 enables range flag
// - config one bit 6 appends checksum byte
// - config one bit 4 picks second-order filter
// - config one bit 3 picks external reference
// - delay code gives 0 to 4096 clock start delay
// - config two bit 7 mirrors data ready
// - config two bit 6 shows clock source
// - sync clock output driven only when enabled
// - config two bit 4 picks pulse control
// - three-bit data rate field, default zero
// - offset word at 3..5, resets zero
// - gain word at 6..8, top byte 40h
// - registers reached only by serial commands
// - start pin high converts, low by commands
// - data ready also on dout and bit
// - read 2r/nn, write 4r/nn command bytes
// - reset command restores registers, restarts filter
// ****************************************************************
`timescale 1ns/1ps
`include "acrb_cfg.svh"
module acrb_top #(
  parameter int TIMEOUT_CYCLES = `ACRB_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  // serial port
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  // control pins
  input  wire logic        start_pin_i,
  input  wire logic        reset_powerdown_pin_n_i,
  output logic             data_ready_n_o,
  output logic             sync_clock_output_o,
  // converter side
  input  wire logic        ext_clk_det_i,
  input  wire logic        conv_done_i,
  output logic             conv_start_o,
  output logic             filter_restart_o,
  output logic             powerdown_o,
  output logic             reference_bias_enable_o,
  output logic             reference_source_o,
  output logic             filter_order_select_o,
  output logic             range_flag_en_o,
  output logic             checksum_append_o,
  output logic [2:0]       data_rate_field_o,
  output logic [23:0]      offset_cal_word_o,
  output logic [23:0]      gain_cal_word_o
);
  localparam acrb_pkg::acrb_regs_t RST_IMAGE = `ACRB_RST_IMAGE;
  localparam acrb_pkg::acrb_regs_t WR_MASK   = `ACRB_WR_MASK;
  localparam logic [16:0]          TO_LAST   = 17'(TIMEOUT_CYCLES - 1);

  acrb_pkg::acrb_core_t s;
  acrb_pkg::acrb_core_t n;
  acrb_link_if          lk ();
  logic                 sclk_s;
  logic                 cs_s;
  logic                 start_s;
  logic                 rstpd_s;
  logic                 tgl_s;

  // ****************************************************************
  // crossings and serial front end
  // ****************************************************************
  acrb_sync #(
    .W (5)
  ) u_sync (
    .clk_i    (clk_i),
    .clk_en_i (clk_en_i),
    .d_i      ({sclk_i, cs_n_i, start_pin_i, reset_powerdown_pin_n_i, lk.rx_byte_tgl}),
    .q_o      ({sclk_s, cs_s, start_s, rstpd_s, tgl_s})
  );

  acrb_link u_link (
    .sclk_i (sclk_i),
    .din_i  (din_i),
    .dout_o (dout_o),
    .lk     (lk.link)
  );

  assign lk.link_clr = s.link_clr;
  assign lk.cont     = s.cont;
  assign lk.data_ready_n_n   = s.data_ready_n_n;
  assign lk.image    = s.image;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic [7:0] b;
    logic       cmd_start;
    logic       trig;
    logic       pulse;
    b         = lk.rx_byte;
    cmd_start = 1'b0;
    trig      = 1'b0;
    pulse     = s.regs[`ACRB_ADDR_CFG2][`ACRB_CFG2_PULSE];
    n            = s;
    n.link_clr   = 1'b0;
    n.conv_start = 1'b0;
    n.filt_rst   = 1'b0;
    n.tgl_prev   = tgl_s;
    n.sclk_prev  = sclk_s;
    n.start_prev = start_s;
    n.oe         = ~cs_s;
    n.pdn        = ~rstpd_s;

    // sclk-low watchdog, fires once per low stretch
    if (sclk_s || !s.regs[`ACRB_ADDR_CFG0][`ACRB_CFG0_TIMEOUT]) begin
      n.to_cnt = '0;
    end else if (s.to_cnt <= TO_LAST) begin
      n.to_cnt = s.to_cnt + 17'h0_0001;
      if (s.to_cnt == TO_LAST) begin
        n.link_clr = 1'b1;
        n.st       = acrb_pkg::ACRB_ST_OPC;
      end
    end

    // deselect drops any half command
    if (cs_s) begin
      n.link_clr = 1'b1;
      n.st       = acrb_pkg::ACRB_ST_OPC;
    end

    // a completed byte from the serial side
    if (tgl_s != s.tgl_prev && !cs_s) begin
      unique case (s.st)
        acrb_pkg::ACRB_ST_OPC: begin
          n.ptr = b[3:0];
          if (s.cont) begin
            if (b == `ACRB_OP_STOP_CONTINUOUS_CMD) n.cont = 1'b0;
          end else if (b[7:4] == `ACRB_OP_REGISTER_READ_CMD) begin
            n.is_wr = 1'b0;
            n.st    = acrb_pkg::ACRB_ST_OP2;
          end else if (b[7:4] == `ACRB_OP_REGISTER_WRITE_CMD) begin
            n.is_wr = 1'b1;
            n.st    = acrb_pkg::ACRB_ST_OP2;
          end else if (b == `ACRB_OP_CONTINUOUS_READ_CMD) begin
            n.cont = 1'b1;
          end else if (b[7:1] == `ACRB_OP_RESET7) begin
            n.regs     = RST_IMAGE;
            n.filt_rst = 1'b1;
            n.run      = 1'b0;
            n.busy     = 1'b0;
            n.dly_act  = 1'b0;
          end else if (b[7:1] == `ACRB_OP_START7) begin
            cmd_start = 1'b1;
            n.run     = ~pulse;
          end else if (b[7:1] == `ACRB_OP_STOP7) begin
            n.run = 1'b0;
          end
        end
        acrb_pkg::ACRB_ST_OP2: begin
          n.left = b[3:0];
          n.st   = s.is_wr ? acrb_pkg::ACRB_ST_WDATA : acrb_pkg::ACRB_ST_RDATA;
        end
        default: begin
          // read-only and reserved bits are masked off on write
          if (s.st == acrb_pkg::ACRB_ST_WDATA && s.ptr <= `ACRB_ADDR_GAIN_HI) begin
            n.regs[s.ptr] = b & WR_MASK[s.ptr];
          end
          n.ptr  = s.ptr + 4'h1;
          n.left = s.left - 4'h1;
          if (s.left == 4'h0) n.st = acrb_pkg::ACRB_ST_OPC;
        end
      endcase
    end

    // conversion triggering: level in gate mode, edge or command in pulse mode
    if (pulse) begin
      trig = ((start_s && !s.start_prev) || cmd_start) && !s.dly_act;
    end else begin
      trig = (start_s || s.run || cmd_start) && !s.busy && !s.dly_act;
    end
    if (trig) begin
      if (s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_DLY_MSB:0] == 3'h0) begin
        n.conv_start = 1'b1;
        n.busy       = 1'b1;
      end else begin
        n.dly_act = 1'b1;
        n.dly_cnt = 13'(`ACRB_DELAY_BASE
                        << (s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_DLY_MSB:0] - 3'h1));
      end
    end else if (s.dly_act) begin
      n.dly_cnt = s.dly_cnt - 13'h0001;
      if (s.dly_cnt == 13'h0001) begin
        n.dly_act    = 1'b0;
        n.conv_start = 1'b1;
        n.busy       = 1'b1;
      end
    end

    // data ready: falls at a result, rises on sclk fall or next start
    if (conv_done_i && s.busy) begin
      n.busy   = 1'b0;
      n.data_ready_n_n = 1'b0;
    end else if (!pulse && s.sclk_prev && !sclk_s) begin
      n.data_ready_n_n = 1'b1;
    end else if (pulse && n.conv_start) begin
      n.data_ready_n_n = 1'b1;
    end

    // sync clock divider, held low when disabled
    if (s.regs[`ACRB_ADDR_CFG2][`ACRB_CFG2_SYNC]) begin
      n.sync_div = s.sync_div + 4'h1;
      if (s.sync_div == `ACRB_SYNC_HALF) begin
        n.sync_div = '0;
        n.sync_q   = ~s.sync_q;
      end
    end else begin
      n.sync_div = '0;
      n.sync_q   = 1'b0;
    end

    // pin reset or power-down, and block reset
    if (!rstpd_s || rst_i) begin
      n.regs     = RST_IMAGE;
      n.run      = 1'b0;
      n.busy     = 1'b0;
      n.dly_act  = 1'b0;
      n.data_ready_n_n   = 1'b1;
      n.st       = acrb_pkg::ACRB_ST_OPC;
      n.link_clr = 1'b1;
      n.cont     = 1'b1;
    end
    if (rst_i) begin
      n          = '0;
      n.regs     = RST_IMAGE;
      n.data_ready_n_n   = 1'b1;
      n.cont     = 1'b1;
      n.link_clr = 1'b1;
    end

    // read image: fixed pattern, factory code and live status bits
    n.image = n.regs;
    n.image[`ACRB_ADDR_CFG0][`ACRB_CFG0_FIX_MSB:`ACRB_CFG0_FIX_LSB] = `ACRB_CFG0_FIXED;
    n.image[`ACRB_ADDR_CFG0][`ACRB_CFG0_ID_MSB:`ACRB_CFG0_ID_LSB] = `ACRB_FACTORY_CODE;
    n.image[`ACRB_ADDR_CFG2][`ACRB_CFG2_DATA_READY_N]   = n.data_ready_n_n;
    n.image[`ACRB_ADDR_CFG2][`ACRB_CFG2_CLKSRC] = ext_clk_det_i;
  end

  // single state register; clock enable freezes it
  always_ff @(posedge clk_i) begin
    if (clk_en_i || rst_i) s <= n;
  end

  // ****************************************************************
  // outputs, all sliced straight from state flops
  // ****************************************************************
  assign dout_oe_o               = s.oe;
  assign data_ready_n_o          = s.data_ready_n_n;
  assign sync_clock_output_o     = s.sync_q;
  assign conv_start_o            = s.conv_start;
  assign filter_restart_o        = s.filt_rst;
  assign powerdown_o             = s.pdn;
  assign reference_bias_enable_o = s.regs[`ACRB_ADDR_CFG0][`ACRB_CFG0_REFERENCE_BIAS_ENABLE];
  assign reference_source_o      = s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_REFSRC];
  assign filter_order_select_o   = s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_FILTER];
  assign range_flag_en_o         = s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_FLAG];
  assign checksum_append_o       = s.regs[`ACRB_ADDR_CFG1][`ACRB_CFG1_CHECKSUM_APPEND];
  assign data_rate_field_o       = s.regs[`ACRB_ADDR_CFG2][`ACRB_CFG2_DR_MSB:0];
  assign offset_cal_word_o       = {s.regs[5], s.regs[4], s.regs[3]};
  assign gain_cal_word_o         = {s.regs[8], s.regs[7], s.regs[6]};

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_fixed_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
    s.image[0][7:6] == 2'b10)
    else $error("fixed read-back pattern wrong");

  a_factory_code: assert property (@(posedge clk_i) disable iff (rst_i)
    s.image[0][5:4] == `ACRB_FACTORY_CODE && s.image[0][3] == 1'b0)
    else $error("factory code bits wrong");

  a_ready_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    s.image[2][7] == data_ready_n_o)
    else $error("data ready bit does not mirror pin");

  a_clock_source: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_en_i |=> s.image[2][6] == $past(ext_clk_det_i))
    else $error("clock source bit not tracking");

  a_sync_held_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_en_i && !s.regs[2][5]) |=> !sync_clock_output_o)
    else $error("sync clock driven while disabled");

  a_reset_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_en_i && tgl_s != s.tgl_prev && !cs_s && rstpd_s && !s.cont
     && s.st == acrb_pkg::ACRB_ST_OPC && lk.rx_byte[7:1] == 7'h03)
    |=> (s.regs == RST_IMAGE && filter_restart_o))
    else $error("reset command did not restore registers");

  a_timeout_fire: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_en_i && !sclk_s && s.regs[0][0] && s.to_cnt == TO_LAST)
    |=> (s.link_clr && s.st == acrb_pkg::ACRB_ST_OPC))
    else $error("timeout did not reframe the port");

  a_delay_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_en_i && !s.dly_act && n.dly_act && rstpd_s)
    |=> s.dly_cnt == (13'h0040 << ($past(s.regs[1][2:0]) - 3'h1)))
    else $error("start delay count wrong");

  a_gate_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_en_i && rstpd_s && !s.regs[2][4] && !(conv_done_i && s.busy)
     && s.sclk_prev && !sclk_s) |=> data_ready_n_o)
    else $error("data ready not released on sclk fall");

  a_ro_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s.regs[0][7:6] == 2'b00 && s.regs[2][7:6] == 2'b00 && s.regs[1][5] == 1'b0)
    else $error("read-only or reserved bit was stored");
endmodule

/* File: src/acrb_cfg.svh */
// register map, field positions, reset values and timing counts of the config bank
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH
// ****************************************************************
// register addresses
// ****************************************************************
`define ACRB_NUM_REGS      9
`define ACRB_ADDR_CFG0     4'h0
`define ACRB_ADDR_CFG1     4'h1
`define ACRB_ADDR_CFG2     4'h2
`define ACRB_ADDR_OFC_LO   4'h3
`define ACRB_ADDR_OFC_HI   4'h5
`define ACRB_ADDR_GAIN_LO  4'h6
`define ACRB_ADDR_GAIN_HI  4'h8
// ****************************************************************
// reset values and write masks, byte 8 leftmost
// ****************************************************************
`define ACRB_RST_IMAGE     72'h40_0000_0000_0000_0805
`define ACRB_WR_MASK       72'hFF_FFFF_FFFF_FF37_DF05
`define ACRB_CFG0_FIXED    2'h2
`define ACRB_FACTORY_CODE  2'h0
// ****************************************************************
// field positions
// ****************************************************************
`define ACRB_CFG0_FIX_MSB  7
`define ACRB_CFG0_FIX_LSB  6
`define ACRB_CFG0_ID_MSB   5
`define ACRB_CFG0_ID_LSB   4
`define ACRB_CFG0_REFERENCE_BIAS_ENABLE    2
`define ACRB_CFG0_TIMEOUT  0
`define ACRB_CFG1_FLAG     7
`define ACRB_CFG1_CHECKSUM_APPEND   6
`define ACRB_CFG1_FILTER   4
`define ACRB_CFG1_REFSRC   3
`define ACRB_CFG1_DLY_MSB  2
`define ACRB_CFG2_DATA_READY_N     7
`define ACRB_CFG2_CLKSRC   6
`define ACRB_CFG2_SYNC     5
`define ACRB_CFG2_PULSE    4
`define ACRB_CFG2_DR_MSB   2
// ****************************************************************
// opcodes
// ****************************************************************
`define ACRB_OP_RESET7     7'h03
`define ACRB_OP_START7     7'h04
`define ACRB_OP_STOP7      7'h05
`define ACRB_OP_CONTINUOUS_READ_CMD     8'h10
`define ACRB_OP_STOP_CONTINUOUS_CMD     8'h11
`define ACRB_OP_REGISTER_READ_CMD       4'h2
`define ACRB_OP_REGISTER_WRITE_CMD       4'h4
// ****************************************************************
// timing in device clock cycles
// ****************************************************************
`define ACRB_TIMEOUT_CYCLES 65536
`define ACRB_DELAY_BASE     13'h0040
`define ACRB_SYNC_HALF      4'h1
`endif

/* File: src/acrb_pkg.sv */
// types of the config register bank
package acrb_pkg;
  `include "acrb_cfg.svh"

  // ****************************************************************
  // command parser states
  // ****************************************************************
  typedef enum logic [1:0] {
    ACRB_ST_OPC   = 2'b00,
    ACRB_ST_OP2   = 2'b01,
    ACRB_ST_WDATA = 2'b10,
    ACRB_ST_RDATA = 2'b11
  } acrb_cmd_st_t;

  typedef logic [`ACRB_NUM_REGS-1:0][7:0] acrb_regs_t;

  // ****************************************************************
  // state of the device-clock side
  // ****************************************************************
  typedef struct packed {
    acrb_cmd_st_t st;
    logic         is_wr;
    logic [3:0]   ptr;
    logic [3:0]   left;
    acrb_regs_t   regs;
    acrb_regs_t   image;
    logic         cont;
    logic         run;
    logic         busy;
    logic         data_ready_n_n;
    logic         dly_act;
    logic [12:0]  dly_cnt;
    logic [16:0]  to_cnt;
    logic         tgl_prev;
    logic         sclk_prev;
    logic         start_prev;
    logic         link_clr;
    logic         conv_start;
    logic         filt_rst;
    logic         oe;
    logic         pdn;
    logic [3:0]   sync_div;
    logic         sync_q;
  } acrb_core_t;

  // ****************************************************************
  // state of the serial-clock side, sampled on falling edges
  // ****************************************************************
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] sh;
    logic [7:0] rx;
    logic       tgl;
    logic [2:0] ph;
    logic [3:0] ptr;
    logic [3:0] left;
  } acrb_link_t;
endpackage

/* File: src/acrb_link_if.sv */
// signals between the device-clock core and the serial-clock front end
`timescale 1ns/1ps
interface acrb_link_if;
  logic                rx_byte_tgl;
  logic [7:0]          rx_byte;
  logic                link_clr;
  logic                cont;
  logic                data_ready_n_n;
  acrb_pkg::acrb_regs_t image;

  modport core (
    input  rx_byte_tgl,
    input  rx_byte,
    output link_clr,
    output cont,
    output data_ready_n_n,
    output image
  );

  modport link (
    output rx_byte_tgl,
    output rx_byte,
    input  link_clr,
    input  cont,
    input  data_ready_n_n,
    input  image
  );
endinterface

/* File: src/acrb_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module acrb_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_i,
  input  wire logic         clk_en_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

/* File: src/acrb_link.sv */
// serial front end on the host clock: byte framing and register read-out
`timescale 1ns/1ps
`include "acrb_cfg.svh"
module acrb_link (
  // serial pins
  input  wire logic sclk_i,
  input  wire logic din_i,
  output logic      dout_o,
  // core side
  acrb_link_if.link lk
);
  localparam logic [2:0] PH_OPC = 3'h0;
  localparam logic [2:0] PH_ROP = 3'h1;
  localparam logic [2:0] PH_WOP = 3'h2;
  localparam logic [2:0] PH_RDT = 3'h3;
  localparam logic [2:0] PH_WDT = 3'h4;

  acrb_pkg::acrb_link_t s;
  acrb_pkg::acrb_link_t n;
  logic [7:0]           nb;
  logic [6:0]           txs_q;
  logic [7:0]           rd_byte;

  // ****************************************************************
  // input shifting, commands are tracked only to find read windows
  // ****************************************************************
  always_comb begin
    n  = s;
    nb = {s.sh, din_i};
    n.sh      = nb[6:0];
    n.bit_cnt = s.bit_cnt + 3'h1;
    if (s.bit_cnt == 3'h7) begin
      n.rx  = nb;
      n.tgl = ~s.tgl;
      unique case (s.ph)
        PH_OPC: begin
          n.ptr = nb[3:0];
          if (!lk.cont && nb[7:4] == `ACRB_OP_REGISTER_READ_CMD) n.ph = PH_ROP;
          if (!lk.cont && nb[7:4] == `ACRB_OP_REGISTER_WRITE_CMD) n.ph = PH_WOP;
        end
        PH_ROP, PH_WOP: begin
          n.left = nb[3:0];
          n.ph   = (s.ph == PH_ROP) ? PH_RDT : PH_WDT;
        end
        default: begin
          n.ptr  = s.ptr + 4'h1;
          n.left = s.left - 4'h1;
          if (s.left == 4'h0) n.ph = PH_OPC;
        end
      endcase
    end
  end

  // cleared by the core on select release, timeout or reset
  always_ff @(negedge sclk_i or posedge lk.link_clr) begin
    if (lk.link_clr) s <= '0;
    else             s <= n;
  end

  assign lk.rx_byte     = s.rx;
  assign lk.rx_byte_tgl = s.tgl;
  // image is quasi-static apart from the live data ready and clock source bits: the rest only moves on writes or resets
  assign rd_byte = (s.ptr <= `ACRB_ADDR_GAIN_HI) ? lk.image[s.ptr] : 8'h00;

  // ****************************************************************
  // output shifting on rising edges; idle line mirrors data ready
  // ****************************************************************
  always_ff @(posedge sclk_i or posedge lk.link_clr) begin
    if (lk.link_clr) begin
      dout_o <= 1'b1;
      txs_q  <= '0;
    end else if (s.ph == PH_RDT && s.bit_cnt == 3'h0) begin
      dout_o <= rd_byte[7];
      txs_q  <= rd_byte[6:0];
    end else if (s.ph == PH_RDT) begin
      dout_o <= txs_q[6];
      txs_q  <= {txs_q[5:0], 1'b0};
    end else begin
      dout_o <= lk.data_ready_n_n;
    end
  end
endmodule

/* File: sim/acrb_host_model.sv */
// serial host model that frames command bytes for the config bank
`timescale 1ns/1ps
module acrb_host_model (
  // serial pins
  input  wire logic       dout_i,
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic            din_o,
  // read-back bytes
  output logic            rx_stb_o,
  output logic [7:0]      rx_o
);
  // ****************************************
  // byte framing, sclk still outside frames
  // ****************************************
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    rx_stb_o = 1'b0;
    rx_o = 8'h00;
  end

  // one byte msb first; din moves after each fall, dout read just before it
  task automatic xb(input logic [7:0] tx, input bit chk);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      #1 din_o = tx[i];
      #39 sclk_o = 1'b1;
      #40 r[i] = dout_i;
      sclk_o = 1'b0;
    end
    if (chk) begin
      rx_o = r;
      rx_stb_o = 1'b1;
      #1 rx_stb_o = 1'b0;
    end
  endtask

  // whole command under one select; the last nchk bytes are read-back data
  task automatic frame(input logic [7:0] b[$], input int nchk);
    cs_n_o = 1'b0;
    #213;
    foreach (b[k]) xb(b[k], k >= b.size() - nchk);
    // select must outlast the last byte's crossing, else the core drops it
    #160 cs_n_o = 1'b1;
    #200;
  endtask

  // a few bits then silence, leaving a byte half sent
  task automatic stub(input int n);
    cs_n_o = 1'b0;
    #213;
    repeat (n) begin
      #1 din_o = 1'b1;
      #39 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
  endtask
endmodule

/* File: sim/adc_config_register_bank_tb_top.sv */
// self-checking bench of the config register bank
`timescale 1ns/1ps
module adc_config_register_bank_tb_top;
  // ****************************************
  // stimulus, partner and result checking
  // ****************************************
  logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, done_i = 1'b0;
  logic sclk, cs_n, din, dout, oe, data_ready_n_n, sync, cst, rx_stb;
  logic [7:0] rx_b;
  logic [7:0] q_exp[$];
  logic [23:0] offset_cal_word, gn, n_conv = 0;
  int n_mismatch = 0, num_checks = 0, n;
  logic en = 1'b1, rpd_n = 1'b1, xclk = 1'b0;

  always #20 clk_i = ~clk_i;
  // dout has a pull-down while the bank lets go of it
  wire dout_w = oe ? dout : 1'b0;
  // configuration levels as seen by the converter
  wire [7:0] cfg_o = {uut.range_flag_en_o, uut.checksum_append_o, uut.filter_order_select_o,
                      uut.reference_source_o, uut.reference_bias_enable_o, uut.data_rate_field_o};

  acrb_top #(.TIMEOUT_CYCLES(64)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(en), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .dout_oe_o(oe), .start_pin_i(start_i),
    .reset_powerdown_pin_n_i(rpd_n), .data_ready_n_o(data_ready_n_n), .sync_clock_output_o(sync),
    .ext_clk_det_i(xclk), .conv_done_i(done_i), .conv_start_o(cst), .filter_restart_o(),
    .powerdown_o(), .reference_bias_enable_o(), .reference_source_o(),
    .filter_order_select_o(), .range_flag_en_o(), .checksum_append_o(),
    .data_rate_field_o(), .offset_cal_word_o(), .gain_cal_word_o());

  acrb_host_model host (.dout_i(dout_w), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .rx_stb_o(rx_stb), .rx_o(rx_b));

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read-back bytes are judged against the oldest note
  always @(posedge rx_stb) begin
    chk("read_byte", q_exp[0], rx_b);
    void'(q_exp.pop_front());
  end

  // conversion starts are counted to catch repeats
  always @(posedge clk_i) if (cst === 1'b1) n_conv <= n_conv + 1;

  task automatic rd(input logic [3:0] a, input logic [7:0] e[$]);
    logic [7:0] b[$];
    b = '{{4'h2, a}, 8'(e.size() - 1)};
    foreach (e[i]) begin
      b.push_back(8'h00);
      q_exp.push_back(e[i]);
    end
    host.frame(b, e.size());
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    logic [7:0] b[$];
    b = '{{4'h4, a}, 8'(d.size() - 1)};
    foreach (d[i]) b.push_back(d[i]);
    host.frame(b, 0);
    repeat (8) @(posedge clk_i);
  endtask

  // clk/4 square wave gives four highs in eight cycles
  task automatic sync_cnt(input logic [23:0] e);
    n = 0;
    repeat (8) begin
      @(posedge clk_i);
      #1 n += int'(sync);
    end
    chk("sync_highs", e, n[23:0]);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // longest wait is the 4096-cycle start delay, far inside this span
  initial begin
    #1_000_000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hc836b62e));
    offset_cal_word = $urandom;
    gn = $urandom;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    host.frame('{8'h11}, 0);
    rd(4'h0, '{8'h85, 8'h08, 8'h80, 0, 0, 0, 0, 0, 8'h40});
    sync_cnt(0);
    wr(4'h0, '{8'hf5, 8'hdf, 8'hf7, offset_cal_word[7:0], offset_cal_word[15:8], offset_cal_word[23:16],
       gn[7:0], gn[15:8], gn[23:16]});
    rd(4'h0, '{8'h85, 8'hdf, 8'hb7, offset_cal_word[7:0], offset_cal_word[15:8], offset_cal_word[23:16],
       gn[7:0], gn[15:8], gn[23:16]});
    chk("offset_word", offset_cal_word, uut.offset_cal_word_o);
    chk("gain_word", gn, uut.gain_cal_word_o);
    chk("cfg_outputs", 24'hff, cfg_o);
    sync_cnt(4);
    // a low enable must hold the running sync clock where it stands
    en <= 1'b0;
    @(posedge clk_i);
    #1 n = int'(sync);
    repeat (6) @(posedge clk_i);
    #1 chk("sync_frozen", n[23:0], 24'(sync));
    en <= 1'b1;
    start_i <= 1'b1;
    n = 0;
    while (cst !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    chk("start_delay_ok", 1, n >= 4096 && n < 4110);
    @(posedge clk_i);
    done_i <= 1'b1;
    @(posedge clk_i);
    done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("data_ready_pin", 0, data_ready_n_n);
    xclk <= 1'b1;
    rd(4'h2, '{8'h77});
    chk("single_start", 1, n_conv);
    start_i <= 1'b0;
    host.frame('{8'h06}, 0);
    repeat (8) @(posedge clk_i);
    host.frame('{8'h11}, 0);
    rd(4'h0, '{8'h85, 8'h08});
    rd(4'h6, '{0, 0, 8'h40});
    chk("cfg_outputs_rst", 24'h18, cfg_o);
    host.stub(3);
    #4000;
    rd(4'h8, '{8'h40});
    wr(4'h3, '{8'h5a});
    rpd_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk("powerdown", 1, uut.powerdown_o);
    chk("offset_pin_reset", 0, uut.offset_cal_word_o);
    rpd_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule
